/* File: adc_source_model.sv */
// ADC sample source: one sample per strobe rising edge, one sample every four clocks
// assumes the bench sets the level to be digitised
`timescale 1ns/1ps
module adc_source_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [11:0] level,
    output logic [11:0]      adcData,
    output logic             adcStrobe
);
    logic [1:0] phase;
    // same period in every range; data change two clocks before each strobe rise
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase     <= 2'h0;
            adcData   <= 12'h000;
            adcStrobe <= 1'b0;
        end else begin
            phase     <= phase + 2'h1;
            adcStrobe <= phase[1];
            if (phase == 2'h0)
                adcData <= level;
        end
    end
endmodule // adc_source_model

/* File: event_fifo.sv */
// event FIFO: DEPTH words in all, the head word held in an output register
// assumes WIDTH matches the width of the connected fifo_if
`timescale 1ns/1ps
module event_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    fifo_if.store     port
);
    localparam int MD = DEPTH - 1;
    localparam int PW = $clog2(MD + 1);

    logic [WIDTH-1:0] mem [MD];
    logic [PW-1:0]    rdPtr;
    logic [PW-1:0]    wrPtr;
    logic [PW:0]      count;
    logic [WIDTH-1:0] head;
    logic             headValid;

    wire push     = port.inValid && port.inReady;
    wire pop      = headValid && port.outReady;
    wire refill   = !headValid || pop;
    wire fromMem  = refill && (count != '0);
    wire bypass   = refill && (count == '0) && push;
    wire toMem    = push && !bypass;
    wire memFull  = (count == (PW+1)'(MD));

    assign port.inReady  = !memFull;
    assign port.outData  = head;
    assign port.outValid = headValid;
    assign port.full     = memFull && headValid;

    function automatic logic [PW-1:0] advance(input logic [PW-1:0] p);
        advance = (p == PW'(MD - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge sys_clk) begin
        if (toMem) begin
            mem[wrPtr] <= port.inData;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdPtr <= '0;
            wrPtr <= '0;
            count <= '0;
        end else begin
            if (toMem) wrPtr <= advance(wrPtr);
            if (fromMem) rdPtr <= advance(rdPtr);
            count <= count + (PW+1)'(toMem) - (PW+1)'(fromMem);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            head      <= '0;
            headValid <= 1'b0;
        end else if (refill) begin
            headValid <= fromMem || bypass;
            if (fromMem) head <= mem[rdPtr];
            else if (bypass) head <= port.inData;
        end
    end
endmodule // event_fifo

/* File: fifo_if.sv */
// valid/ready carrier between the pulse logic and its event FIFO
// assumes both ends run on one clock
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 32);
    logic [WIDTH-1:0] inData;
    logic             inValid;
    logic             inReady;
    logic [WIDTH-1:0] outData;
    logic             outValid;
    logic             outReady;
    logic             full;

    modport user  (output inData, inValid, outReady, input inReady, outData, outValid, full);
    modport store (input inData, inValid, outReady, output inReady, outData, outValid, full);
endinterface

/* File: tb_top.sv */
// bench: register table, single pulse, pileup pair, reset in mid-run
// assumes zero-wait AHB-Lite answers and the ADC source model
`timescale 1ns/1ps
`include "trap_defs.svh"
module tb_top;
    typedef struct packed { logic w; logic [7:0] a; logic [31:0] d, m, e; } row_s;
    localparam row_s ROWS [18] = '{
        '{1'b0, `OFS_CTRL, 32'h0, 32'hffffffff, `RST_CTRL},
        '{1'b0, `OFS_FAST_TIMING, 32'h0, 32'hffffffff, `RST_FAST_TIMING},
        '{1'b0, `OFS_SLOW_TIMING, 32'h0, 32'hffffffff, `RST_SLOW_TIMING},
        '{1'b0, `OFS_THRESHOLD, 32'h0, 32'hffffffff, 32'(`RST_THRESHOLD)},
        '{1'b0, `OFS_PEAK_DELAY, 32'h0, 32'hffffffff, 32'(`RST_PEAK_DELAY)},
        '{1'b0, `OFS_PILEUP_WIN, 32'h0, 32'hffffffff, 32'(`RST_PILEUP_WIN)},
        '{1'b0, `OFS_DECAY_MULT, 32'h0, 32'hffffffff, 32'(`RST_DECAY_MULT)},
        '{1'b0, 8'h30, 32'h0, 32'hffffffff, 32'h0},
        '{1'b1, `OFS_REJECTS, 32'h5, 32'h0, 32'h0},
        '{1'b0, `OFS_REJECTS, 32'h0, 32'hffffffff, 32'h0},
        '{1'b1, `OFS_FAST_TIMING, 32'h2864, 32'h0, 32'h0},
        '{1'b0, `OFS_STATUS, 32'h0, 32'h4, 32'h4},
        '{1'b1, `OFS_FAST_TIMING, 32'h0302, 32'h0, 32'h0},
        '{1'b0, `OFS_STATUS, 32'h0, 32'h4, 32'h0},
        '{1'b1, `OFS_PEAK_DELAY, 32'h12, 32'h0, 32'h0},
        '{1'b0, `OFS_PEAK_DELAY, 32'h0, 32'hffffffff, 32'h12},
        '{1'b1, `OFS_PILEUP_WIN, 32'h16, 32'h0, 32'h0},
        '{1'b1, `OFS_DECAY_MULT, 32'hffff, 32'h0, 32'h0}};
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [11:0] level = 12'h000;
    logic [11:0] adcData;
    logic        adcStrobe, hreadyout, hresp, fastTrigger, eventTrigger;
    logic [31:0] hrdata, rd;
    int          badCount = 0, nCompared = 0, fastCnt = 0, evCnt = 0;
    always #12.5 sys_clk = ~sys_clk;
    trapezoid_pulse_pileup_filter i_dut (.sys_clk, .sys_rst, .adcData, .adcStrobe, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .fastTrigger, .eventTrigger);
    adc_source_model i_adc (.sys_clk, .sys_rst, .level, .adcData, .adcStrobe);
    always @(posedge sys_clk) begin
        if (fastTrigger === 1'b1)
            fastCnt++;
        if (eventTrigger === 1'b1)
            evCnt++;
    end
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task automatic giveVerdict();
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // a hang costs at most 20000 clocks, several times the planned run
    initial begin
        repeat (20000) @(posedge sys_clk);
        badCount++;
        giveVerdict();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (300) @(posedge sys_clk);
        foreach (ROWS[i]) begin
            bus(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].w)
                cmp($sformatf("reg %h", ROWS[i].a), ROWS[i].e, rd & ROWS[i].m);
        end
        // step sampled 19 ticks after the crossing lands in the slow flat top
        repeat (300) @(posedge sys_clk);
        level <= 12'h3e8;
        repeat (500) @(posedge sys_clk);
        cmp("fast count", 1, fastCnt);
        cmp("event count", 1, evCnt);
        bus(1'b0, `OFS_STATUS, 32'h0);
        cmp("avail", 32'h1, rd & 32'h1);
        bus(1'b0, `OFS_EVENT, 32'h0);
        cmp("event word", 32'h80003e80, rd);
        bus(1'b0, `OFS_STATUS, 32'h0);
        cmp("avail after pop", 32'h0, rd & 32'h1);
        bus(1'b0, `OFS_FAST_SUM, 32'h0);
        cmp("fast sum flat", 32'h0, rd);
        bus(1'b0, `OFS_SLOW_SUM, 32'h0);
        cmp("slow sum flat", 32'h0, rd);
        level <= 12'h000;
        bus(1'b1, `OFS_CTRL, 32'h5);
        repeat (600) @(posedge sys_clk);
        level <= 12'h3e8;
        repeat (160) @(posedge sys_clk);
        level <= 12'h7d0;
        repeat (900) @(posedge sys_clk);
        cmp("fast count pair", 3, fastCnt);
        cmp("event count pair", 1, evCnt);
        bus(1'b0, `OFS_REJECTS, 32'h0);
        cmp("rejects", 32'h1, rd);
        level <= 12'h000;
        repeat (100) @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        bus(1'b0, `OFS_REJECTS, 32'h0);
        cmp("rejects after reset", 32'h0, rd);
        bus(1'b0, `OFS_CTRL, 32'h0);
        cmp("ctrl after reset", `RST_CTRL, rd);
        giveVerdict();
    end
endmodule // tb_top

/* File: trap_defs.svh */
// register map, field positions, reset values and timing figures of the pulse filter
// assumes the including file uses these as sized values where it needs them
`ifndef TRAP_DEFS_SVH
`define TRAP_DEFS_SVH

`define OFS_CTRL        8'h00
`define OFS_FAST_TIMING 8'h04
`define OFS_SLOW_TIMING 8'h08
`define OFS_THRESHOLD   8'h0c
`define OFS_PEAK_DELAY  8'h10
`define OFS_PILEUP_WIN  8'h14
`define OFS_DECAY_MULT  8'h18
`define OFS_STATUS      8'h1c
`define OFS_EVENT       8'h20
`define OFS_FAST_SUM    8'h24
`define OFS_SLOW_SUM    8'h28
`define OFS_REJECTS     8'h2c

`define CTRL_EN_BIT     0
`define CTRL_RANGE_LSB  1
`define TIM_GAP_LSB     8
`define EVT_VALID_BIT   31

`define RST_CTRL        32'h0000_0003
`define RST_FAST_TIMING 32'h0000_0302
`define RST_SLOW_TIMING 32'h0000_0510
`define RST_THRESHOLD   16'h0040
`define RST_PEAK_DELAY  10'h014
`define RST_PILEUP_WIN  10'h016
`define RST_DECAY_MULT  16'hffff

`define ADC_PERIOD_NS   10
`define GRAN_RANGE1_NS  20
`define MAX_RANGE       3'h6
`define MAX_RISE_FLAT   8'h7f
`define MIN_RISE_TICKS  7'h02
`define MIN_FLAT_TICKS  7'h03
`define DECAY_FRAC      16
`define HIST_DEPTH      256

`endif

/* File: trap_pkg.sv */
// types used by the pulse filter only: its state encoding and its running-sum type
// assumes trap_defs.svh supplies the numeric constants
package trap_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_TRACK = 3'b010,
        ST_EMIT  = 3'b100
    } pulse_state_e;

    typedef logic signed [23:0] sum_t;

endpackage

/* File: trap_pulse_asserts.sv */
// checker on the pulse filter top ports
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module trap_pulse_asserts (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        fastTrigger,
    input wire logic        eventTrigger
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [8:0] sinceRst;
    logic [7:0] credit;
    wire        rdTaken = hsel && htrans[1] && hready && !hwrite;
    // credit is only an upper bound: rejected pulses leave theirs behind
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sinceRst <= 9'h000;
            credit   <= 8'h00;
        end else begin
            if (!sinceRst[8])
                sinceRst <= sinceRst + 9'h001;
            credit <= credit + 8'(fastTrigger) - 8'(eventTrigger);
        end
    end
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rdata_holds: assert property (!rdTaken |=> $stable(hrdata))
        else $error("hrdata moved without a read");
    a_unmapped_zero: assert property (rdTaken && haddr[7:0] > 8'h2c |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_fast_rearm: assert property (fastTrigger |=> !fastTrigger [*7])
        else $error("fast trigger repeated too soon");
    a_event_pulse: assert property (eventTrigger |=> !eventTrigger)
        else $error("event trigger longer than one cycle");
    a_event_credit: assert property (eventTrigger |-> credit != 8'h00)
        else $error("event without fast trigger");
    a_flush_quiet: assert property (!sinceRst[8] |-> !fastTrigger && !eventTrigger)
        else $error("trigger during history flush");
    c_fast: cover property (fastTrigger);
    c_event: cover property (eventTrigger);
    c_pair: cover property (fastTrigger ##[8:400] fastTrigger);
endmodule // trap_pulse_asserts

bind trapezoid_pulse_pileup_filter trap_pulse_asserts i_chk (.sys_clk, .sys_rst, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .fastTrigger,
    .eventTrigger);

/* File: trapezoid_pulse_pileup_filter.sv */
// realtime filter unit: decimation, fast and slow trapezoid, trigger, pileup, event FIFO
// assumes an AHB-Lite master on sys_clk and an ADC stream from outside the clock domain
//
// Operation
// - two trapezoid filters per channel: a fast one for arrivals, a slow one for amplitude.
// - each filter is recomputed per tick: the last L samples minus the L before a gap of G.
// - a fast crossing starts a counter; the slow value after the peak delay is the amplitude.
// - filter sums keep updating and stay readable; new data are taken right after a readout.
// - a second arrival within the pileup window after an arrival rejects the first pulse.
// - the later pulse that caused a pileup rejection is rejected as well.
// - an event trigger is given only if no pileup is seen in the window after the fast trigger.
// - input samples are taken at the fixed ADC period of 10 ns in every range.
// - range n averages 2 to the n ADC samples into one value before the filters.
// - rise time plus flat top may not exceed 127 decimated cycles.
// - filter granularity is 20 ns in range 1 and doubles per range up to 640 ns in range 6.
// - least rise time is two and least flat top three decimated cycles in every range.
// - one logic serves all ranges and one written range field selects the active one.
// - the baseline follows the decay by the host factor and is taken off the amplitude.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "trap_defs.svh"
module trapezoid_pulse_pileup_filter
    import trap_pkg::*;
#(
    parameter int ADC_W      = 12,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic [ADC_W-1:0]  adcData,
    input  wire logic              adcStrobe,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    output logic                   fastTrigger,
    output logic                   eventTrigger
);
    localparam int ACC_W = ADC_W + 6;

    // ---- pin synchronisers
    logic [ADC_W-1:0] adcMeta;
    logic [ADC_W-1:0] adcSync;
    logic             strobeMeta;
    logic             strobeSync;
    logic             strobeLast;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {adcMeta, adcSync} <= '0;
            {strobeMeta, strobeSync, strobeLast} <= '0;
        end else begin
            adcMeta    <= adcData;
            adcSync    <= adcMeta;
            strobeMeta <= adcStrobe;
            strobeSync <= strobeMeta;
            strobeLast <= strobeSync;
        end
    end

    // one sample per strobe edge: the ADC sets the 10 ns period, not sys_clk
    wire sampleTake = strobeSync && !strobeLast;

    // ---- software registers
    logic [31:0] ctrl;
    logic [31:0] fastTiming;
    logic [31:0] slowTiming;
    logic [15:0] threshold;
    logic [9:0]  peakDelay;
    logic [9:0]  pileupWindow;
    logic [15:0] decayMult;
    logic [31:0] rejectCount;

    wire       enable   = ctrl[`CTRL_EN_BIT];
    wire [2:0] rangeRaw = ctrl[`CTRL_RANGE_LSB +: 3];
    // one datapath for all ranges; out-of-table codes fold to the top range
    wire [2:0] range    = (rangeRaw > `MAX_RANGE) ? `MAX_RANGE : rangeRaw;

    function automatic logic [6:0] atLeast(input logic [6:0] v, input logic [6:0] lo);
        atLeast = (v < lo) ? lo : v;
    endfunction

    // lengths below the least settings are raised to them
    wire [6:0] fastLen = atLeast(fastTiming[6:0], `MIN_RISE_TICKS);
    wire [6:0] fastGap = atLeast(fastTiming[`TIM_GAP_LSB +: 7], `MIN_FLAT_TICKS);
    wire [6:0] slowLen = atLeast(slowTiming[6:0], `MIN_RISE_TICKS);
    wire [6:0] slowGap = atLeast(slowTiming[`TIM_GAP_LSB +: 7], `MIN_FLAT_TICKS);

    wire [7:0] slowSpan = {1'b0, slowLen} + {1'b0, slowGap};
    wire [7:0] fastSpan = {1'b0, fastLen} + {1'b0, fastGap};
    wire configError = (slowSpan > `MAX_RISE_FLAT) || (fastSpan > `MAX_RISE_FLAT);

    // ---- decimation: 2^range samples averaged per filter tick
    logic [ACC_W-1:0] decAcc;
    logic [5:0]       decCount;
    logic [ADC_W-1:0] decSample;
    logic             decTick;

    wire [5:0]       decLast = 6'((7'h01 << range) - 7'h01);
    wire [ACC_W-1:0] accSum  = decAcc + ACC_W'(adcSync);
    // granularity is ADC period times 2^range: 20 ns in range 1, 640 ns in range 6
    wire [ADC_W-1:0] avg     = ADC_W'(accSum >> range);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            decAcc    <= '0;
            decCount  <= '0;
            decSample <= '0;
            decTick   <= 1'b0;
        end else begin
            decTick <= sampleTake && (decCount == decLast);
            if (sampleTake) begin
                decAcc   <= (decCount == decLast) ? '0 : accSum;
                decCount <= (decCount == decLast) ? '0 : decCount + 6'h01;
                if (decCount == decLast) decSample <= avg;
            end
        end
    end

    // ---- sample history shared by both filters
    logic [ADC_W-1:0] hist [`HIST_DEPTH];
    logic [7:0]       histPtr;
    logic [8:0]       flushCount;

    // while disabled the history is zeroed so the running sums restart clean
    wire flushing = !enable || (flushCount != '0);
    wire histStep = flushing || decTick;
    wire [ADC_W-1:0] histIn = flushing ? '0 : decSample;

    function automatic logic [ADC_W-1:0] tap(input logic [7:0] back);
        tap = hist[histPtr - back];
    endfunction

    always_ff @(posedge sys_clk) begin
        if (histStep) hist[histPtr] <= histIn;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            histPtr    <= '0;
            flushCount <= 9'(`HIST_DEPTH);
        end else begin
            if (histStep) histPtr <= histPtr + 8'h01;
            if (!enable) flushCount <= 9'(`HIST_DEPTH);
            else if (flushCount != '0) flushCount <= flushCount - 9'h001;
        end
    end

    // ---- running sums, both filters updated on every tick
    sum_t fastLead;
    sum_t fastTrail;
    sum_t slowLead;
    sum_t slowTrail;

    wire [7:0] fL  = {1'b0, fastLen};
    wire [7:0] fLG = fastSpan;
    wire [7:0] f2  = fastSpan + fL;
    wire [7:0] sL  = {1'b0, slowLen};
    wire [7:0] sLG = slowSpan;
    wire [7:0] s2  = slowSpan + sL;

    wire sum_t fastOut = fastLead - fastTrail;
    wire sum_t slowOut = slowLead - slowTrail;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {fastLead, fastTrail, slowLead, slowTrail} <= '0;
        end else if (flushing) begin
            {fastLead, fastTrail, slowLead, slowTrail} <= '0;
        end else if (decTick) begin
            fastLead  <= fastLead + sum_t'(decSample) - sum_t'(tap(fL));
            fastTrail <= fastTrail + sum_t'(tap(fLG)) - sum_t'(tap(f2));
            slowLead  <= slowLead + sum_t'(decSample) - sum_t'(tap(sL));
            slowTrail <= slowTrail + sum_t'(tap(sLG)) - sum_t'(tap(s2));
        end
    end

    // ---- threshold with rearm
    logic wasAbove;
    wire  above    = fastOut >= sum_t'(threshold);
    wire  crossing = decTick && above && !wasAbove && !flushing;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) wasAbove <= 1'b0;
        else if (decTick) wasAbove <= above;
    end

    // ---- baseline followed along the preamp decay
    sum_t baseline;
    wire signed [40:0] decayProd = baseline * $signed({1'b0, decayMult});
    wire sum_t decayedBase = sum_t'(decayProd >>> `DECAY_FRAC);

    // ---- pulse tracking
    pulse_state_e state;
    pulse_state_e next_state;
    logic [9:0]   peakCount;
    logic [9:0]   windowCount;
    logic         captured;
    logic         piled;
    sum_t         amplitude;

    fifo_if #(.WIDTH(32)) evq ();

    wire peakDue    = (state == ST_TRACK) && decTick && (peakCount == '0) && !captured;
    wire windowDone = (state == ST_TRACK) && (windowCount == '0) && captured && !crossing;
    wire accepted   = (state == ST_EMIT) && evq.inReady;
    wire rejectNow  = windowDone && piled;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:  if (crossing) next_state = ST_TRACK;
            ST_TRACK: if (windowDone) next_state = piled ? ST_IDLE : ST_EMIT;
            ST_EMIT:  if (evq.inReady) next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) state <= ST_IDLE;
        else state <= next_state;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            peakCount   <= '0;
            windowCount <= '0;
            captured    <= 1'b0;
            piled       <= 1'b0;
        end else if (crossing && state != ST_EMIT) begin
            peakCount   <= peakDelay;
            windowCount <= pileupWindow;
            captured    <= 1'b0;
            // an arrival inside the window kills the pending pulse and marks the new one too
            piled       <= (state == ST_TRACK);
        end else if (state == ST_TRACK && decTick) begin
            if (peakCount != '0) peakCount <= peakCount - 10'h001;
            if (windowCount != '0) windowCount <= windowCount - 10'h001;
            if (peakDue) captured <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            amplitude <= '0;
            baseline  <= '0;
        end else if (peakDue) begin
            amplitude <= slowOut - decayedBase;
        end else if (state == ST_IDLE && decTick && !above) begin
            baseline <= slowOut;
        end else if (decTick) begin
            baseline <= decayedBase;
        end
    end

    // crossings that meet a full FIFO in ST_EMIT are dropped; the stall is the back-pressure
    assign evq.inValid = (state == ST_EMIT);
    assign evq.inData  = {1'b1, 7'h00, amplitude};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fastTrigger  <= 1'b0;
            eventTrigger <= 1'b0;
            rejectCount  <= '0;
        end else begin
            fastTrigger  <= crossing;
            eventTrigger <= accepted;
            if (rejectNow) rejectCount <= rejectCount + 32'h1;
        end
    end

    // ---- AHB-Lite slave, zero wait states
    logic       wrPend;
    logic [7:0] wrOfs;

    wire        take   = hsel && htrans[1] && hready;
    wire [7:0]  ofs    = haddr[7:0];
    wire        rdTake = take && !hwrite;
    wire        popEvt = rdTake && (ofs == `OFS_EVENT);
    wire [31:0] status = {28'h0, (state != ST_IDLE), configError, evq.full, evq.outValid};

    // reading the event word pops it, so the next event is ready at once
    assign evq.outReady = popEvt;

    event_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .port    (evq.store)
    );

    logic [31:0] rdMux;
    always_comb begin
        unique case (ofs)
            `OFS_CTRL:        rdMux = ctrl;
            `OFS_FAST_TIMING: rdMux = fastTiming;
            `OFS_SLOW_TIMING: rdMux = slowTiming;
            `OFS_THRESHOLD:   rdMux = {16'h0, threshold};
            `OFS_PEAK_DELAY:  rdMux = {22'h0, peakDelay};
            `OFS_PILEUP_WIN:  rdMux = {22'h0, pileupWindow};
            `OFS_DECAY_MULT:  rdMux = {16'h0, decayMult};
            `OFS_STATUS:      rdMux = status;
            `OFS_EVENT:       rdMux = evq.outValid ? evq.outData : 32'h0;
            `OFS_FAST_SUM:    rdMux = 32'(fastOut);
            `OFS_SLOW_SUM:    rdMux = 32'(slowOut);
            `OFS_REJECTS:     rdMux = rejectCount;
            default:          rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
            wrPend    <= 1'b0;
            wrOfs     <= '0;
        end else begin
            if (rdTake) hrdata <= rdMux;
            wrPend <= take && hwrite;
            if (take) wrOfs <= ofs;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl         <= `RST_CTRL;
            fastTiming   <= `RST_FAST_TIMING;
            slowTiming   <= `RST_SLOW_TIMING;
            threshold    <= `RST_THRESHOLD;
            peakDelay    <= `RST_PEAK_DELAY;
            pileupWindow <= `RST_PILEUP_WIN;
            decayMult    <= `RST_DECAY_MULT;
        end else if (wrPend) begin
            unique case (wrOfs)
                `OFS_CTRL:        ctrl <= hwdata & 32'h0000_000f;
                `OFS_FAST_TIMING: fastTiming <= hwdata & 32'h0000_7f7f;
                `OFS_SLOW_TIMING: slowTiming <= hwdata & 32'h0000_7f7f;
                `OFS_THRESHOLD:   threshold <= hwdata[15:0];
                `OFS_PEAK_DELAY:  peakDelay <= hwdata[9:0];
                `OFS_PILEUP_WIN:  pileupWindow <= hwdata[9:0];
                `OFS_DECAY_MULT:  decayMult <= hwdata[15:0];
                default:          ;
            endcase
        end
    end
endmodule // trapezoid_pulse_pileup_filter
